// >>> pfsa_device.sv
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
// Operation
// RQ1 - Read fetches word in second cycle
// RQ2 - Fetched word lands in data pair next
// RQ3 - Data pair holds until read or write
// RQ4 - Core idles two slots after read strobe
// RQ5 - Wrong space select drops write strobe
// RQ6 - Protected segments refuse program writes
// RQ7 - Blocks are eight aligned sequential words
// RQ8 - Commit erases sixteen, writes eight, aligned
// RQ9 - Unlock 55h then AAh before strobe
// RQ10 - Software fills all eight buffer words
// RQ11 - Only last word address commits buffer
// RQ12 - Software repeats sequence, ascending order
// RQ13 - Two setup cycles follow write strobe
// RQ14 - First seven words load without stall
// RQ15 - Core halted during erase, clocks run
// RQ16 - Core resumes after write finishes
// RQ17 - Software rewrites upper eight words too
// RQ18 - Power-up clears write allow
// RQ19 - Power-up timer blocks writes
// RQ20 - Write strobe set-only, hardware cleared
// RQ21 - Completion sets sticky done flag
// RQ22 - Reset during write sets abort flag
// RQ23 - Unlock port reads zero, stores nothing
// RQ24 - Arm only on consecutive 55h, AAh
module pfsa_device #(
   parameter int PWRT_CYCLES = pfsa_pkg::PWRT_CYCLES,
   parameter int ERASE_CYCLES = pfsa_pkg::ERASE_CYCLES
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Core access
   pfsa_if.flash bus,
   // System side
   input wire logic sys_reset_req,
   input wire logic [1:0] protect_range,
   input wire logic write_done_clear,
   output logic write_done_flag,
   output logic write_busy,
   output logic pwrt_running
);
   localparam int AW = pfsa_pkg::ADDR_W;
   localparam int WW = pfsa_pkg::WORD_W;

   logic [WW-1:0] flash_mem [pfsa_pkg::MEM_WORDS];
   logic [WW-1:0] buffer_mem [pfsa_pkg::BLOCK_WORDS];

   logic [7:0] nv_addr_low_reg;
   logic [4:0] nv_addr_high_reg;
   logic [7:0] nv_data_low_reg;
   logic [5:0] nv_data_high_reg;
   logic space_select_reg;
   logic write_abort_reg;
   logic write_allow_reg;
   logic wr_reg;
   logic rd_reg;
   logic [1:0] rd_phase_reg;
   logic write_done_reg;
   logic [7:0] rdata_reg;
   logic [31:0] pwrt_cnt_reg;
   logic [31:0] erase_cnt_reg;
   logic [1:0] setup_cnt_reg;
   logic [3:0] prog_idx_reg;
   pfsa_pkg::pfsa_wstate_type wstate_reg;

   logic [AW-1:0] prog_addr;
   logic ctl_wr;
   logic unlock_wr;
   logic wr_attempt;
   logic rd_attempt;
   logic armed;
   logic prot_hit;
   logic wr_accept;
   logic commit;
   logic fetch_now;
   logic abort_now;
   logic prog_last;
   logic [AW-1:0] prog_target;

   assign prog_addr = {nv_addr_high_reg, nv_addr_low_reg};
   assign ctl_wr = bus.reg_wr && (bus.reg_sel == pfsa_pkg::SEL_CONTROL);
   assign unlock_wr = bus.reg_wr && (bus.reg_sel == pfsa_pkg::SEL_UNLOCK);
   assign wr_attempt = ctl_wr && bus.reg_wdata[pfsa_pkg::CTL_WR] && !wr_reg;
   assign rd_attempt = ctl_wr && bus.reg_wdata[pfsa_pkg::CTL_RD] && !rd_reg;
   assign abort_now = sys_reset_req && (wstate_reg != pfsa_pkg::W_IDLE);
   assign commit = prog_addr[2:0] == pfsa_pkg::LAST_IN_BLOCK; // [RQ11]
   assign pwrt_running = pwrt_cnt_reg < 32'(PWRT_CYCLES);

   always_comb begin
      case (protect_range) // [RQ6]
         2'b11: prot_hit = 1'b0;
         2'b10: prot_hit = prog_addr < pfsa_pkg::PROT_LIMIT_10;
         2'b01: prot_hit = prog_addr < pfsa_pkg::PROT_LIMIT_01;
         2'b00: prot_hit = prog_addr < pfsa_pkg::PROT_LIMIT_00;
         default: prot_hit = 1'b1;
      endcase
   end

   // Strobe is taken only with allow, unlock, timer expired, program space
   assign wr_accept = wr_attempt && write_allow_reg && armed && !pwrt_running && // [RQ19] [RQ20]
      space_select_reg && !prot_hit && (wstate_reg == pfsa_pkg::W_IDLE); // [RQ5] [RQ6]

   pfsa_unlock unlock_u (
      .ref_clk(ref_clk),
      .rst(rst || sys_reset_req),
      .port_wr(unlock_wr),
      .port_data(bus.reg_wdata),
      .consume(wr_attempt),
      .armed(armed)
   );

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pwrt_cnt_reg <= 32'h0000_0000;
      end else if (pwrt_running) begin
         pwrt_cnt_reg <= pwrt_cnt_reg + 32'h0000_0001; // [RQ19]
      end
   end

   // Address and data registers
   always_ff @(posedge ref_clk) begin
      if (rst || sys_reset_req) begin
         nv_addr_low_reg <= pfsa_pkg::ADDR_LOW_RST;
         nv_addr_high_reg <= pfsa_pkg::ADDR_HIGH_RST;
      end else if (bus.reg_wr && bus.reg_sel == pfsa_pkg::SEL_ADDR_LOW) begin
         nv_addr_low_reg <= bus.reg_wdata;
      end else if (bus.reg_wr && bus.reg_sel == pfsa_pkg::SEL_ADDR_HIGH) begin
         nv_addr_high_reg <= bus.reg_wdata[4:0];
      end
   end

   assign fetch_now = rd_phase_reg == 2'h2;

   always_ff @(posedge ref_clk) begin
      if (rst || sys_reset_req) begin
         nv_data_low_reg <= pfsa_pkg::DATA_LOW_RST;
         nv_data_high_reg <= pfsa_pkg::DATA_HIGH_RST;
      end else if (fetch_now) begin
         {nv_data_high_reg, nv_data_low_reg} <= flash_mem[prog_addr]; // [RQ1] [RQ2]
      end else if (bus.reg_wr && bus.reg_sel == pfsa_pkg::SEL_DATA_LOW) begin
         nv_data_low_reg <= bus.reg_wdata; // [RQ3]
      end else if (bus.reg_wr && bus.reg_sel == pfsa_pkg::SEL_DATA_HIGH) begin
         nv_data_high_reg <= bus.reg_wdata[5:0]; // [RQ3]
      end
   end

   // Control bits
   always_ff @(posedge ref_clk) begin
      if (rst || sys_reset_req) begin
         space_select_reg <= 1'b0;
         write_allow_reg <= 1'b0; // [RQ18]
      end else if (ctl_wr) begin
         space_select_reg <= bus.reg_wdata[pfsa_pkg::CTL_SPACE];
         write_allow_reg <= bus.reg_wdata[pfsa_pkg::CTL_ALLOW];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         write_abort_reg <= 1'b0;
      end else if (abort_now) begin
         write_abort_reg <= 1'b1; // [RQ22]
      end else if (wstate_reg == pfsa_pkg::W_PROG && prog_last) begin
         write_abort_reg <= 1'b0; // [RQ22]
      end else if (ctl_wr) begin
         write_abort_reg <= bus.reg_wdata[pfsa_pkg::CTL_ABORT];
      end
   end

   // Read strobe: slot 1 runs, slot 2 is the fetch, data is ready after it
   always_ff @(posedge ref_clk) begin
      if (rst || sys_reset_req) begin
         rd_reg <= 1'b0;
         rd_phase_reg <= 2'h0;
      end else if (rd_attempt && space_select_reg) begin
         rd_reg <= 1'b1;
         rd_phase_reg <= 2'h1; // [RQ1]
      end else if (rd_phase_reg != 2'h0) begin
         rd_reg <= !fetch_now;
         rd_phase_reg <= fetch_now ? 2'h0 : rd_phase_reg + 2'h1;
      end
   end

   assign bus.fetch_slot = fetch_now; // [RQ1] [RQ4]

   // Write sequencer
   assign prog_last = prog_idx_reg == 4'(pfsa_pkg::ERASE_WORDS - 1);
   assign prog_target = {prog_addr[AW-1:4], prog_idx_reg}; // [RQ8]

   always_ff @(posedge ref_clk) begin
      if (rst || sys_reset_req) begin
         wstate_reg <= pfsa_pkg::W_IDLE;
         wr_reg <= 1'b0;
         setup_cnt_reg <= 2'h0;
         erase_cnt_reg <= 32'h0000_0000;
         prog_idx_reg <= 4'h0;
      end else begin
         case (wstate_reg)
            pfsa_pkg::W_IDLE: begin
               if (wr_accept) begin
                  wr_reg <= 1'b1; // [RQ20]
                  setup_cnt_reg <= 2'h0;
                  wstate_reg <= pfsa_pkg::W_SETUP;
               end
            end
            pfsa_pkg::W_SETUP: begin
               setup_cnt_reg <= setup_cnt_reg + 2'h1;
               if (setup_cnt_reg == 2'(pfsa_pkg::SETUP_CYCLES - 1)) begin // [RQ13]
                  if (commit) begin
                     erase_cnt_reg <= 32'h0000_0000;
                     wstate_reg <= pfsa_pkg::W_ERASE;
                  end else begin
                     wr_reg <= 1'b0; // [RQ14]
                     wstate_reg <= pfsa_pkg::W_IDLE;
                  end
               end
            end
            pfsa_pkg::W_ERASE: begin
               erase_cnt_reg <= erase_cnt_reg + 32'h0000_0001;
               if (erase_cnt_reg == 32'(ERASE_CYCLES - 1)) begin // [RQ15]
                  prog_idx_reg <= 4'h0;
                  wstate_reg <= pfsa_pkg::W_PROG;
               end
            end
            pfsa_pkg::W_PROG: begin
               prog_idx_reg <= prog_idx_reg + 4'h1;
               if (prog_last) begin
                  wr_reg <= 1'b0; // [RQ20] [RQ16]
                  wstate_reg <= pfsa_pkg::W_IDLE;
               end
            end
            default: begin
               wr_reg <= 1'b0;
               wstate_reg <= pfsa_pkg::W_IDLE;
            end
         endcase
      end
   end

   // Buffer load on the two-cycle setup's first cycle of every word, the last word included
   always_ff @(posedge ref_clk) begin
      if (wstate_reg == pfsa_pkg::W_SETUP && setup_cnt_reg == 2'h0) begin
         buffer_mem[prog_addr[2:0]] <= {nv_data_high_reg, nv_data_low_reg}; // [RQ7] [RQ14]
      end
   end

   // Erase the aligned sixteen, refill the half that holds this block
   always_ff @(posedge ref_clk) begin
      if (wstate_reg == pfsa_pkg::W_PROG) begin
         if (prog_idx_reg[3] == prog_addr[3]) begin
            flash_mem[prog_target] <= buffer_mem[prog_idx_reg[2:0]]; // [RQ8] [RQ11]
         end else begin
            flash_mem[prog_target] <= pfsa_pkg::ERASED_WORD; // [RQ8] [RQ17]
         end
      end
   end

   // Hardware set wins over software clear
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         write_done_reg <= 1'b0;
      end else if (wstate_reg == pfsa_pkg::W_PROG && prog_last) begin
         write_done_reg <= 1'b1; // [RQ21]
      end else if (write_done_clear) begin
         write_done_reg <= 1'b0; // [RQ21]
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdata_reg <= 8'h00;
      end else if (bus.reg_rd) begin
         case (bus.reg_sel)
            pfsa_pkg::SEL_ADDR_LOW: rdata_reg <= nv_addr_low_reg;
            pfsa_pkg::SEL_ADDR_HIGH: rdata_reg <= {3'h0, nv_addr_high_reg};
            pfsa_pkg::SEL_DATA_LOW: rdata_reg <= nv_data_low_reg;
            pfsa_pkg::SEL_DATA_HIGH: rdata_reg <= {2'h0, nv_data_high_reg};
            pfsa_pkg::SEL_CONTROL: rdata_reg <= {space_select_reg, 3'h0, write_abort_reg,
               write_allow_reg, wr_reg, rd_reg};
            default: rdata_reg <= 8'h00; // [RQ23]
         endcase
      end
   end

   assign bus.reg_rdata = rdata_reg;
   assign bus.halt = (wstate_reg == pfsa_pkg::W_ERASE) || (wstate_reg == pfsa_pkg::W_PROG); // [RQ15]
   assign write_done_flag = write_done_reg;
   assign write_busy = wstate_reg != pfsa_pkg::W_IDLE;
endmodule

// >>> pfsa_pkg.sv
package pfsa_pkg;
   // Core-side register selects
   localparam logic [2:0] SEL_ADDR_LOW = 3'h0;
   localparam logic [2:0] SEL_ADDR_HIGH = 3'h1;
   localparam logic [2:0] SEL_DATA_LOW = 3'h2;
   localparam logic [2:0] SEL_DATA_HIGH = 3'h3;
   localparam logic [2:0] SEL_CONTROL = 3'h4;
   localparam logic [2:0] SEL_UNLOCK = 3'h5;
   // Control register fields
   localparam int CTL_RD = 0;
   localparam int CTL_WR = 1;
   localparam int CTL_ALLOW = 2;
   localparam int CTL_ABORT = 3;
   localparam int CTL_SPACE = 7;
   // Widths
   localparam int ADDR_W = 13;
   localparam int WORD_W = 14;
   localparam int MEM_WORDS = 8192;
   localparam int BLOCK_WORDS = 8;
   localparam int ERASE_WORDS = 16;
   // Reset values, erased word and last word index
   localparam logic [7:0] ADDR_LOW_RST = 8'h00;
   localparam logic [4:0] ADDR_HIGH_RST = 5'h00;
   localparam logic [7:0] DATA_LOW_RST = 8'h00;
   localparam logic [5:0] DATA_HIGH_RST = 6'h00;
   localparam logic [WORD_W-1:0] ERASED_WORD = 14'h3fff;
   localparam logic [2:0] LAST_IN_BLOCK = 3'h7;
   // Unlock keys
   localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
   localparam logic [7:0] UNLOCK_KEY2 = 8'haa;
   // Write-protected spans, words below the limit are protected
   localparam logic [ADDR_W-1:0] PROT_LIMIT_10 = 13'h0100;
   localparam logic [ADDR_W-1:0] PROT_LIMIT_01 = 13'h0800;
   localparam logic [ADDR_W-1:0] PROT_LIMIT_00 = 13'h1000;
   // Timing
   localparam int CLK_MHZ = 200;
   localparam int PWRT_MS = 64;
   localparam int ERASE_MS = 4;
   localparam int PWRT_CYCLES = PWRT_MS * 1000 * CLK_MHZ;
   localparam int ERASE_CYCLES = ERASE_MS * 1000 * CLK_MHZ;
   localparam int SETUP_CYCLES = 2;
   localparam int NOP_CYCLES = 2;
   // Host APB map
   localparam logic [7:0] APB_CMD = 8'h00;
   localparam logic [7:0] APB_STATUS = 8'h04;
   localparam int CMD_SEL_LSB = 8;
   localparam int CMD_WRITE = 12;
   localparam int CMD_READ = 13;
   // Write sequencer states
   typedef enum logic [1:0] {
      W_IDLE = 2'b00,
      W_SETUP = 2'b01,
      W_ERASE = 2'b11,
      W_PROG = 2'b10
   } pfsa_wstate_type;
   // Host access states
   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_ISSUE = 2'b01,
      H_GAP = 2'b11,
      H_DONE = 2'b10
   } pfsa_hstate_type;
endpackage

// >>> pfsa_if.sv
`timescale 1ns/1ps
interface pfsa_if;
   logic reg_wr;
   logic reg_rd;
   logic [2:0] reg_sel;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic halt;
   logic fetch_slot;
   modport core (
      output reg_wr, reg_rd, reg_sel, reg_wdata,
      input reg_rdata, halt, fetch_slot
   );
   modport flash (
      input reg_wr, reg_rd, reg_sel, reg_wdata,
      output reg_rdata, halt, fetch_slot
   );
endinterface

// >>> pfsa_unlock.sv
`timescale 1ns/1ps
module pfsa_unlock (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Unlock port writes
   input wire logic port_wr,
   input wire logic [7:0] port_data,
   // Strobe attempt consumes the arming
   input wire logic consume,
   output logic armed
);
   logic half_reg;
   logic armed_reg;

   always_ff @(posedge ref_clk) begin
      if (rst || consume) begin
         half_reg <= 1'b0;
      end else if (port_wr) begin
         half_reg <= (port_data == pfsa_pkg::UNLOCK_KEY1); // [RQ24]
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst || consume) begin
         armed_reg <= 1'b0;
      end else if (port_wr) begin
         armed_reg <= half_reg && (port_data == pfsa_pkg::UNLOCK_KEY2); // [RQ24] [RQ9]
      end
   end

   assign armed = armed_reg;
endmodule

// >>> pfsa_host.sv
`timescale 1ns/1ps
module pfsa_host (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Flash access
   pfsa_if.core bus
);
   pfsa_pkg::pfsa_hstate_type hstate_reg;
   logic [7:0] wdata_reg;
   logic [2:0] sel_reg;
   logic is_write_reg;
   logic is_read_reg;
   logic [1:0] gap_cnt_reg;
   logic [7:0] last_rdata_reg;
   logic cmd_hit;
   logic status_hit;
   logic busy;

   assign cmd_hit = paddr == pfsa_pkg::APB_CMD;
   assign status_hit = paddr == pfsa_pkg::APB_STATUS;
   assign busy = hstate_reg != pfsa_pkg::H_IDLE;
   // A command write waits for the previous access to finish
   assign pready = !(psel && penable && pwrite && cmd_hit && busy);
   assign pslverr = psel && penable && !cmd_hit && !status_hit;

   always_comb begin
      prdata = 32'h0000_0000;
      if (status_hit) begin
         prdata = {16'h0000, last_rdata_reg, 6'h00, bus.halt, busy};
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         hstate_reg <= pfsa_pkg::H_IDLE;
         wdata_reg <= 8'h00;
         sel_reg <= 3'h0;
         is_write_reg <= 1'b0;
         is_read_reg <= 1'b0;
         gap_cnt_reg <= 2'h0;
      end else begin
         case (hstate_reg)
            pfsa_pkg::H_IDLE: begin
               if (psel && penable && pwrite && cmd_hit) begin
                  wdata_reg <= pwdata[7:0];
                  sel_reg <= pwdata[pfsa_pkg::CMD_SEL_LSB +: 3];
                  is_write_reg <= pwdata[pfsa_pkg::CMD_WRITE];
                  is_read_reg <= pwdata[pfsa_pkg::CMD_READ];
                  hstate_reg <= pfsa_pkg::H_ISSUE;
               end
            end
            pfsa_pkg::H_ISSUE: begin
               gap_cnt_reg <= 2'h0;
               hstate_reg <= pfsa_pkg::H_GAP;
            end
            pfsa_pkg::H_GAP: begin
               // Two idle slots after every access, longer while halted
               if (gap_cnt_reg != 2'(pfsa_pkg::NOP_CYCLES)) begin
                  gap_cnt_reg <= gap_cnt_reg + 2'h1; // [RQ4] [RQ13]
               end else if (!bus.halt) begin
                  hstate_reg <= pfsa_pkg::H_DONE; // [RQ16]
               end
            end
            pfsa_pkg::H_DONE: begin
               hstate_reg <= pfsa_pkg::H_IDLE;
            end
            default: begin
               hstate_reg <= pfsa_pkg::H_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         last_rdata_reg <= 8'h00;
      end else if (hstate_reg == pfsa_pkg::H_DONE && is_read_reg) begin
         last_rdata_reg <= bus.reg_rdata;
      end
   end

   assign bus.reg_wr = (hstate_reg == pfsa_pkg::H_ISSUE) && is_write_reg; // [RQ9] [RQ12]
   assign bus.reg_rd = (hstate_reg == pfsa_pkg::H_ISSUE) && is_read_reg;
   assign bus.reg_sel = sel_reg;
   assign bus.reg_wdata = wdata_reg;
endmodule

// >>> pfsa_chk.sv
`timescale 1ns/1ps
module pfsa_chk #(
   parameter int ERASE_CYCLES = 10
) (
   // Clock and resets
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic sys_reset_req,
   // Link signals
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [2:0] reg_sel,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic halt,
   input wire logic fetch_slot
);
   logic space_reg;
   logic key1_reg;
   logic armed_reg;
   logic strobe_ok_reg;
   logic sys_reg;
   logic [7:0] addr_low_reg;
   int halt_cnt;
   wire ctl_wr = reg_wr && reg_sel == pfsa_pkg::SEL_CONTROL;
   wire unl_wr = reg_wr && reg_sel == pfsa_pkg::SEL_UNLOCK;
   wire rd_go = ctl_wr && reg_wdata[pfsa_pkg::CTL_RD] && space_reg;
   wire wr_go = ctl_wr && reg_wdata[pfsa_pkg::CTL_WR];
   wire no_commit = addr_low_reg[2:0] != pfsa_pkg::LAST_IN_BLOCK ||
      (!space_reg && !reg_wdata[pfsa_pkg::CTL_SPACE]);

   // Mirror of the select and address the device acts on
   always_ff @(posedge ref_clk) begin
      if (rst || sys_reset_req) begin
         space_reg <= 1'b0;
         addr_low_reg <= 8'h00;
      end else begin
         if (ctl_wr)
            space_reg <= reg_wdata[pfsa_pkg::CTL_SPACE];
         if (reg_wr && reg_sel == pfsa_pkg::SEL_ADDR_LOW)
            addr_low_reg <= reg_wdata;
      end
   end

   // Unlock tracking, every strobe attempt spends the arming
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         key1_reg <= 1'b0;
         armed_reg <= 1'b0;
         strobe_ok_reg <= 1'b0;
      end else if (unl_wr) begin
         key1_reg <= reg_wdata == pfsa_pkg::UNLOCK_KEY1;
         armed_reg <= key1_reg && reg_wdata == pfsa_pkg::UNLOCK_KEY2;
      end else if (wr_go) begin
         armed_reg <= 1'b0;
         strobe_ok_reg <= armed_reg;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst || !halt)
         halt_cnt <= 0;
      else
         halt_cnt <= halt_cnt + 1;
   end

   // Reset or an aborted write may drop halt early
   always_ff @(posedge ref_clk) begin
      sys_reg <= sys_reset_req || rst;
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   sequence s_access;
      reg_wr || reg_rd;
   endsequence
   sequence s_fetch;
      !fetch_slot ##1 fetch_slot ##1 !fetch_slot;
   endsequence

   property p_fetch;
      rd_go |=> s_fetch;
   endproperty
   a_fetch: assert property (p_fetch)
      else $error("read fetch not in second slot");
   property p_fetch_cause;
      fetch_slot |-> $past(rd_go, 2);
   endproperty
   a_fetch_cause: assert property (p_fetch_cause)
      else $error("fetch slot without read strobe");
   property p_rdata_hold;
      !reg_rd |=> $stable(reg_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("read data changed without a read");
   property p_unlock_zero;
      reg_rd && reg_sel == pfsa_pkg::SEL_UNLOCK |=> reg_rdata == 8'h00;
   endproperty
   a_unlock_zero: assert property (p_unlock_zero)
      else $error("unlock port read not zero");
   property p_gap;
      s_access |=> !(reg_wr || reg_rd) [*2];
   endproperty
   a_gap: assert property (p_gap)
      else $error("access within two slots of a strobe");
   property p_no_halt;
      wr_go && no_commit |=> !halt [*4];
   endproperty
   a_no_halt: assert property (p_no_halt)
      else $error("buffer load or refused strobe stalled core");
   property p_halt_last;
      $rose(halt) |-> addr_low_reg[2:0] == pfsa_pkg::LAST_IN_BLOCK && strobe_ok_reg;
   endproperty
   a_halt_last: assert property (p_halt_last)
      else $error("commit without last word or unlock");
   property p_halt_quiet;
      halt |-> !reg_wr && !reg_rd;
   endproperty
   a_halt_quiet: assert property (p_halt_quiet)
      else $error("core access during halt");
   property p_halt_len;
      $fell(halt) && !sys_reg |-> halt_cnt >= ERASE_CYCLES && halt_cnt <= ERASE_CYCLES + 20;
   endproperty
   a_halt_len: assert property (p_halt_len)
      else $error("halt length off");
   property p_halt_bound;
      halt |-> halt_cnt < ERASE_CYCLES + 20;
   endproperty
   a_halt_bound: assert property (p_halt_bound)
      else $error("core never resumed");
endmodule

// >>> program_flash_self_access_bench.sv
`timescale 1ns/1ps
module program_flash_self_access_bench;
   localparam int PWRT = 200;
   localparam int ERASE = 10;
   localparam logic [7:0] PREP [7] = '{8'h84, 8'h80, 8'h04, 8'h84, 8'h84, 8'h84, 8'h84};
   localparam logic [7:0] STRB [7] = '{8'h86, 8'h82, 8'h06, 8'h86, 8'h86, 8'h86, 8'h86};
   localparam logic [1:0] PROT [7] = '{2'b11, 2'b11, 2'b11, 2'b11, 2'b10, 2'b01, 2'b00};
   localparam logic [12:0] ADDR [7] = '{13'h1fff, 13'h1fff, 13'h1fff, 13'h1fff, 13'h00ff,
      13'h07ff, 13'h0fff};
   localparam logic [6:0] BAD = 7'h08;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic sys_reset_req = 1'b0;
   logic [1:0] protect_range = 2'b11;
   logic write_done_clear = 1'b0;
   logic write_done_flag;
   logic write_busy;
   logic pwrt_running;
   int n_fail = 0;
   int samples_checked = 0;
   int mem[int];
   int wbuf[$];

   pfsa_if link();
   pfsa_host i_pfsa_host (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .bus(link.core));
   pfsa_device #(.PWRT_CYCLES(PWRT), .ERASE_CYCLES(ERASE)) i_pfsa_device (.ref_clk(ref_clk),
      .rst(rst), .bus(link.flash), .sys_reset_req(sys_reset_req), .protect_range(protect_range),
      .write_done_clear(write_done_clear), .write_done_flag(write_done_flag),
      .write_busy(write_busy), .pwrt_running(pwrt_running));
   pfsa_chk #(.ERASE_CYCLES(ERASE)) i_pfsa_chk (.ref_clk(ref_clk), .rst(rst),
      .sys_reset_req(sys_reset_req), .reg_wr(link.reg_wr), .reg_rd(link.reg_rd),
      .reg_sel(link.reg_sel), .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata),
      .halt(link.halt), .fetch_slot(link.fetch_slot));

   always #2.5 ref_clk = ~ref_clk;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      if (n_fail == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] q, output logic e);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 5000);
      if (n == 5000)
         n_fail++;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask

   // One core access through the command register, then poll until idle
   task automatic op(input logic w, input logic [2:0] s, input logic [7:0] d, input logic cut,
         output logic [7:0] q);
      logic [31:0] r;
      logic e;
      int n;
      apb(1'b1, pfsa_pkg::APB_CMD, {18'h0_0000, !w, w, 1'b0, s, d}, r, e);
      n = 0;
      do begin
         apb(1'b0, pfsa_pkg::APB_STATUS, 32'h0000_0000, r, e);
         if (cut && r[1] === 1'b1) begin
            sys_reset_req <= 1'b1;
            @(posedge ref_clk);
            sys_reset_req <= 1'b0;
            cut = 1'b0;
         end
         n++;
      end while (r[0] !== 1'b0 && n < 500);
      if (r[0] !== 1'b0)
         n_fail++;
      q = r[15:8];
   endtask

   task automatic wr(input logic [2:0] s, input logic [7:0] d);
      logic [7:0] q;
      op(1'b1, s, d, 1'b0, q);
   endtask

   task automatic rd(input logic [2:0] s, output logic [7:0] q);
      op(1'b0, s, 8'h00, 1'b0, q);
   endtask

   task automatic ldw(input int a, input int d, input logic [7:0] prep, input logic bad);
      wr(pfsa_pkg::SEL_ADDR_LOW, a[7:0]);
      wr(pfsa_pkg::SEL_ADDR_HIGH, {3'b000, a[12:8]});
      wr(pfsa_pkg::SEL_DATA_LOW, d[7:0]);
      wr(pfsa_pkg::SEL_DATA_HIGH, {2'b00, d[13:8]});
      wr(pfsa_pkg::SEL_CONTROL, prep);
      wr(pfsa_pkg::SEL_UNLOCK, pfsa_pkg::UNLOCK_KEY1);
      if (bad)
         wr(pfsa_pkg::SEL_UNLOCK, 8'h12);
      wr(pfsa_pkg::SEL_UNLOCK, pfsa_pkg::UNLOCK_KEY2);
   endtask

   // Load eight words, commit, then read back the whole erase region
   task automatic block(input int b);
      logic [7:0] lo;
      logic [7:0] hi;
      int r;
      wbuf.delete();
      for (int j = 0; j < 8; j++) begin
         wbuf.push_back($urandom % 16384);
         ldw(b + j, wbuf[j], 8'h84, 1'b0);
         wr(pfsa_pkg::SEL_CONTROL, 8'h86);
         chk(write_done_flag, j == 7);
      end
      r = b & ~15;
      for (int j = 0; j < 16; j++)
         mem[r + j] = ((j / 8) == ((b / 8) % 2)) ? wbuf[j % 8] : pfsa_pkg::ERASED_WORD;
      rd(pfsa_pkg::SEL_CONTROL, lo);
      chk({lo[pfsa_pkg::CTL_WR], lo[pfsa_pkg::CTL_ABORT]}, 2'b00);
      for (int j = 0; j < 16; j++) begin
         ldw(r + j, 0, 8'h85, 1'b0);
         rd(pfsa_pkg::SEL_DATA_LOW, lo);
         rd(pfsa_pkg::SEL_DATA_HIGH, hi);
         chk({hi[5:0], lo}, mem[r + j]);
      end
      chk(write_done_flag, 1'b1);
      write_done_clear <= 1'b1;
      @(posedge ref_clk);
      write_done_clear <= 1'b0;
      @(posedge ref_clk);
      chk(write_done_flag, 1'b0);
   endtask

   initial begin
      logic [7:0] q;
      logic [31:0] r;
      logic e;
      int base;
      void'($urandom(32'h24d4));
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      rd(pfsa_pkg::SEL_CONTROL, q);
      chk(q[pfsa_pkg::CTL_ALLOW], 1'b0);
      // Strobes that must all be refused at a last-word address
      for (int i = 0; i < 7; i++) begin
         protect_range <= PROT[i];
         ldw(ADDR[i], $urandom % 16384, PREP[i], BAD[i]);
         wr(pfsa_pkg::SEL_CONTROL, STRB[i]);
         chk(pwrt_running, i == 0);
         rd(pfsa_pkg::SEL_CONTROL, q);
         chk(q[pfsa_pkg::CTL_WR], 1'b0);
         chk({write_done_flag, write_busy}, 2'b00);
         repeat (PWRT) if (pwrt_running === 1'b1) @(posedge ref_clk);
      end
      protect_range <= 2'b00;
      base = 4096 + ($urandom % 256) * 16;
      block(base);
      block(base + 8);
      rd(pfsa_pkg::SEL_DATA_HIGH, q);
      chk(q, mem[base + 15] >> 8);
      wr(pfsa_pkg::SEL_DATA_LOW, 8'h5a);
      rd(pfsa_pkg::SEL_DATA_LOW, q);
      chk(q, 8'h5a);
      rd(pfsa_pkg::SEL_UNLOCK, q);
      chk(q, 8'h00);
      apb(1'b0, 8'h08, 32'h0000_0000, r, e);
      chk({e, r[30:0]}, 32'h8000_0000);
      // Commit cut short by a system reset while the core is halted
      ldw(base + 7, 0, 8'h84, 1'b0);
      op(1'b1, pfsa_pkg::SEL_CONTROL, 8'h86, 1'b1, q);
      rd(pfsa_pkg::SEL_CONTROL, q);
      chk({q[pfsa_pkg::CTL_ABORT], q[pfsa_pkg::CTL_WR]}, 2'b10);
      chk(write_done_flag, 1'b0);
      summarize();
   end

   initial begin
      repeat (60000) @(posedge ref_clk);
      n_fail++;
      summarize();
   end
endmodule
